// ==== intc_pkg.sv ====
package intc_pkg;

	// ==================================================
	// Sizes
	localparam int NUM_VEC = 16;
	localparam int VEC_PER_WORD = 4;
	localparam int PRIO_WORDS = NUM_VEC / VEC_PER_WORD;
	localparam int NUM_EXT = 5;
	localparam int EXT_VEC_BASE = 3;
	localparam int PRIO_W = 3;
	localparam int SUB_W = 2;
	localparam int SET_W = 4;
	localparam int VEC_OUT_W = 8;
	localparam int ADDR_W = 12;
	localparam int VEC_FIELD_W = 8;
	localparam int SYNC_DEPTH = 3;

	// ==================================================
	// Control word fields
	localparam int POL_LSB = 0;
	localparam int TPC_LSB = 8;
	localparam int MULTI_VECTOR_SELECT_BIT = 12;
	localparam int SS0_BIT = 16;
	localparam logic [31:0] CTRL_MASK = 32'h0001171F;
	localparam logic [31:0] SMAP_MASK = 32'hFFFFFFF0;
	localparam int SUB_LSB = 0;
	localparam int GRP_LSB = 2;
	localparam int STAT_VEC_LSB = 0;
	localparam int STAT_RPL_LSB = 8;
	localparam int STAT_RUN_BIT = 16;

	// ==================================================
	// Shadow sets: set 0 is the primary set
	localparam logic [SET_W-1:0] PRIMARY_SET = 4'h0;
	localparam logic [SET_W-1:0] SV_SHADOW_SET = 4'h1;
	localparam logic [SET_W-1:0] MAX_SHADOW_SET = 4'h1;

	// ==================================================
	// Register map: base at +0 write, +4 clear, +8 set
	localparam logic [ADDR_W-1:0] REG_CTRL = 12'h000;
	localparam logic [ADDR_W-1:0] REG_STAT = 12'h010;
	localparam logic [ADDR_W-1:0] REG_TMR = 12'h020;
	localparam logic [ADDR_W-1:0] REG_FLAG = 12'h030;
	localparam logic [ADDR_W-1:0] REG_EN = 12'h040;
	localparam logic [ADDR_W-1:0] REG_SMAP = 12'h050;
	localparam logic [3:0] PRIO_IDX0 = 4'h6;
	localparam logic [1:0] OP_WR = 2'h0;
	localparam logic [1:0] OP_CLR = 2'h1;
	localparam logic [1:0] OP_SET = 2'h2;
	localparam logic [31:0] REG_RST = 32'h00000000;

	typedef struct packed {
		logic irq;
		logic [PRIO_W-1:0] level;
		logic [VEC_OUT_W-1:0] vector;
		logic [SET_W-1:0] shadow;
	} core_req_s;

	function automatic logic [31:0] apply_op(input logic [31:0] old, input logic [31:0] wd,
		input logic [1:0] op);
		case (op)
			OP_WR: apply_op = wd;
			OP_CLR: apply_op = old & ~wd;
			OP_SET: apply_op = old | wd;
			default: apply_op = old;
		endcase
	endfunction

endpackage

// ==== edge_catch.sv ====
module edge_catch
	import intc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic pin,
	input wire logic rise_sel,
	output logic edge_pulse
);

	// ==================================================
	// Synchroniser: stage 0 feeds only stage 1
	logic [SYNC_DEPTH-1:0] sync_q;
	logic level_q;
	logic stable;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sync_q <= '0;
		end else if (ce) begin
			sync_q <= {sync_q[SYNC_DEPTH-2:0], pin};
		end
	end

	assign stable = (sync_q[1] == sync_q[2]);

	// ==================================================
	// A change counts once two late stages agree
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			level_q <= 1'b0;
			edge_pulse <= 1'b0;
		end else if (ce) begin
			edge_pulse <= 1'b0;
			if (stable && (sync_q[2] != level_q)) begin
				level_q <= sync_q[2];
				edge_pulse <= (sync_q[2] == rise_sel);
			end
		end
	end

endmodule

// ==== rank_select.sv ====
module rank_select
	import intc_pkg::*;
#(
	parameter int N = NUM_VEC
) (
	input wire logic [N-1:0] cand,
	input wire logic [N*PRIO_W-1:0] grp,
	input wire logic [N*SUB_W-1:0] sub,
	output logic found,
	output logic [VEC_OUT_W-1:0] idx,
	output logic [PRIO_W-1:0] grp_win
);

	logic [SUB_W-1:0] sub_win;

	// Ascending scan with strict compare keeps the lowest vector on a full tie
	always_comb begin
		found = 1'b0;
		idx = '0;
		grp_win = '0;
		sub_win = '0;
		for (int i = 0; i < N; i++) begin
			if (cand[i] && (!found || {grp[i*PRIO_W +: PRIO_W], sub[i*SUB_W +: SUB_W]} >
				{grp_win, sub_win})) begin
				found = 1'b1;
				idx = VEC_OUT_W'(i);
				grp_win = grp[i*PRIO_W +: PRIO_W];
				sub_win = sub[i*SUB_W +: SUB_W];
			end
		end
	end

endmodule

// ==== vectored_priority_interrupt_ctrl.sv ====
// Behaviour
// - 3-bit group priority, 1 lowest, 7 highest
// - Group priority zero disables the vector
// - Higher group priority preempts, lower does not
// - One priority word holds four vectors
// - 2-bit subpriority orders within one group
// - Subpriority never preempts, higher selected first
// - Full tie: lowest vector number wins
// - Request taken only above core priority
// - Single-vector: select bit picks shadow or primary
// - Multi-vector: shadow set chosen by priority
// - Per-level shadow map; unimplemented set means none
// - Five edge-sensitive external inputs, per-input polarity
// - Polarity at control bit n, 0 falling
// - Threshold at bits 10:8, zero disables timer
// - Low request reloads timer from reload value
// - Low requests held off while window runs
// - Timer decrements each clock, reads show count, or reload value at zero
// - At zero, queued requests served above core
// - Timer register holds 32-bit reload value
// - Control bit 12 selects multi-vector operation
// - Single-vector presents vector number zero
module vectored_priority_interrupt_ctrl
	import intc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NUM_VEC-1:0] src_event,
	input wire logic [NUM_EXT-1:0] external_request_inputs,
	input wire logic [PRIO_W-1:0] core_current_priority,
	output core_req_s core_req
);

	// ==================================================
	// Register state
	logic [31:0] ctrl_q;
	logic [31:0] reload_q;
	logic [31:0] cnt_q;
	logic [NUM_VEC-1:0] flag_q;
	logic [NUM_VEC-1:0] en_q;
	logic [31:0] smap_q;
	logic [31:0] prio_q [PRIO_WORDS];

	logic [PRIO_W-1:0] proximity_priority_threshold;
	logic multi_vector_select;
	logic ss0;
	assign proximity_priority_threshold = ctrl_q[TPC_LSB +: PRIO_W];
	assign multi_vector_select = ctrl_q[MULTI_VECTOR_SELECT_BIT];
	assign ss0 = ctrl_q[SS0_BIT];

	// ==================================================
	// APB decode
	logic [ADDR_W-1:0] base;
	logic [1:0] op;
	logic prio_hit;
	logic [1:0] pidx;
	logic hit;
	logic take;
	logic wr;
	logic [31:0] rd_mux;
	logic [31:0] stat_word;
	logic [31:0] tmr_view;

	assign base = {paddr[ADDR_W-1:4], 4'h0};
	assign op = paddr[3:2];
	assign prio_hit = (paddr[ADDR_W-1:8] == '0) && (paddr[7:4] >= PRIO_IDX0) &&
		(paddr[7:4] < PRIO_IDX0 + 4'(PRIO_WORDS));
	assign pidx = 2'(paddr[7:4] - PRIO_IDX0);
	assign take = psel && penable && pready;
	assign wr = take && pwrite && hit;

	always_comb begin
		hit = 1'b0;
		rd_mux = REG_RST;
		if (paddr[1:0] == 2'h0 && op != 2'h3) begin
			if (prio_hit) begin
				hit = 1'b1;
				rd_mux = prio_q[pidx];
			end else begin
				case (base)
					REG_CTRL: begin
						hit = 1'b1;
						rd_mux = ctrl_q;
					end
					REG_STAT: begin
						hit = (op == OP_WR);
						rd_mux = stat_word;
					end
					REG_TMR: begin
						hit = 1'b1;
						rd_mux = tmr_view;
					end
					REG_FLAG: begin
						hit = 1'b1;
						rd_mux = 32'(flag_q);
					end
					REG_EN: begin
						hit = 1'b1;
						rd_mux = 32'(en_q);
					end
					REG_SMAP: begin
						hit = 1'b1;
						rd_mux = smap_q;
					end
					default: begin
						hit = 1'b0;
						rd_mux = REG_RST;
					end
				endcase
			end
		end
	end

	// One wait state lets the read mux settle into a flop
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pready <= 1'b0;
			prdata <= REG_RST;
			pslverr <= 1'b0;
		end else if (ce) begin
			pready <= psel && penable && !pready;
			if (psel && penable && !pready) begin
				prdata <= pwrite ? REG_RST : rd_mux;
				pslverr <= !hit;
			end
		end
	end

	// ==================================================
	// Software-written registers
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ctrl_q <= REG_RST;
		end else if (ce && wr && base == REG_CTRL && !prio_hit) begin
			ctrl_q <= apply_op(ctrl_q, pwdata, op) & CTRL_MASK;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			reload_q <= REG_RST;
		end else if (ce && wr && base == REG_TMR && !prio_hit) begin
			reload_q <= apply_op(reload_q, pwdata, op);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			en_q <= '0;
		end else if (ce && wr && base == REG_EN && !prio_hit) begin
			en_q <= NUM_VEC'(apply_op(32'(en_q), pwdata, op));
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			smap_q <= REG_RST;
		end else if (ce && wr && base == REG_SMAP && !prio_hit) begin
			smap_q <= apply_op(smap_q, pwdata, op) & SMAP_MASK;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			for (int w = 0; w < PRIO_WORDS; w++) begin
				prio_q[w] <= REG_RST;
			end
		end else if (ce && wr && prio_hit) begin
			prio_q[pidx] <= apply_op(prio_q[pidx], pwdata, op);
		end
	end

	// ==================================================
	// Per-vector fields
	logic [NUM_VEC*PRIO_W-1:0] grp_flat;
	logic [NUM_VEC*SUB_W-1:0] sub_flat;
	logic [NUM_VEC-1:0] live;
	logic [NUM_VEC-1:0] low;
	logic [NUM_VEC-1:0] cand;

	always_comb begin
		for (int v = 0; v < NUM_VEC; v++) begin
			grp_flat[v*PRIO_W +: PRIO_W] =
				prio_q[v / VEC_PER_WORD][(v % VEC_PER_WORD)*VEC_FIELD_W + GRP_LSB +: PRIO_W];
			sub_flat[v*SUB_W +: SUB_W] =
				prio_q[v / VEC_PER_WORD][(v % VEC_PER_WORD)*VEC_FIELD_W + SUB_LSB +: SUB_W];
			live[v] = en_q[v] && (grp_flat[v*PRIO_W +: PRIO_W] != '0);
			low[v] = (proximity_priority_threshold != '0) && (grp_flat[v*PRIO_W +: PRIO_W] <= proximity_priority_threshold);
			cand[v] = flag_q[v] && live[v] && !(low[v] && cnt_q != '0);
		end
	end

	// ==================================================
	// External inputs and source flags
	logic [NUM_EXT-1:0] ext_edge;
	logic [NUM_VEC-1:0] set_ev;

	for (genvar n = 0; n < NUM_EXT; n++) begin : g_ext
		edge_catch u_edge (
			.ref_clk(ref_clk),
			.srst(srst),
			.ce(ce),
			.pin(external_request_inputs[n]),
			.rise_sel(ctrl_q[POL_LSB + n]),
			.edge_pulse(ext_edge[n])
		);
	end

	assign set_ev = src_event | (NUM_VEC'(ext_edge) << EXT_VEC_BASE);

	// Hardware set wins over a software clear in the same cycle
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			flag_q <= '0;
		end else if (ce) begin
			if (wr && base == REG_FLAG && !prio_hit) begin
				flag_q <= NUM_VEC'(apply_op(32'(flag_q), pwdata, op)) | set_ev;
			end else begin
				flag_q <= flag_q | set_ev;
			end
		end
	end

	// ==================================================
	// Proximity timer
	logic low_arrival;
	assign low_arrival = |(set_ev & live & low);
	assign tmr_view = (cnt_q != '0) ? cnt_q : reload_q;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cnt_q <= REG_RST;
		end else if (ce) begin
			if (proximity_priority_threshold == '0) begin
				cnt_q <= REG_RST;
			end else if (low_arrival) begin
				cnt_q <= reload_q;
			end else if (cnt_q != '0) begin
				cnt_q <= cnt_q - 32'h00000001;
			end
		end
	end

	// ==================================================
	// Selection and core request
	logic found;
	logic [VEC_OUT_W-1:0] win_idx;
	logic [PRIO_W-1:0] win_grp;
	logic [SET_W-1:0] map_set;
	logic [SET_W-1:0] set_d;

	rank_select #(
		.N(NUM_VEC)
	) u_rank (
		.cand(cand),
		.grp(grp_flat),
		.sub(sub_flat),
		.found(found),
		.idx(win_idx),
		.grp_win(win_grp)
	);

	assign map_set = smap_q[win_grp*SET_W +: SET_W];

	always_comb begin
		if (!found) begin
			set_d = PRIMARY_SET;
		end else if (!multi_vector_select) begin
			set_d = ss0 ? SV_SHADOW_SET : PRIMARY_SET;
		end else if (map_set > MAX_SHADOW_SET) begin
			set_d = PRIMARY_SET;
		end else begin
			set_d = map_set;
		end
	end

	// Core priority comes from same-clock logic, so it is used unsynchronised
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			core_req <= '0;
		end else if (ce) begin
			core_req.irq <= found && (win_grp > core_current_priority);
			core_req.level <= found ? win_grp : '0;
			core_req.vector <= (found && multi_vector_select) ? win_idx : '0;
			core_req.shadow <= set_d;
		end
	end

	assign stat_word = (32'(core_req.vector) << STAT_VEC_LSB) |
		(32'(core_req.level) << STAT_RPL_LSB) | (32'(cnt_q != '0) << STAT_RUN_BIT);

	// ==================================================
	// Checks
	sequence low_load_s;
		ce && proximity_priority_threshold != '0 && low_arrival;
	endsequence

	sequence count_step_s;
		ce && proximity_priority_threshold != '0 && !low_arrival && cnt_q != '0;
	endsequence

	chk_taken_above_core: assert property (@(posedge ref_clk) disable iff (srst)
		ce && found && win_grp > core_current_priority |=> core_req.irq && core_req.level ==
		$past(win_grp)) else $error("request above core priority not raised");
	chk_not_taken_below: assert property (@(posedge ref_clk) disable iff (srst)
		ce && !(found && win_grp > core_current_priority) |=> !core_req.irq)
		else $error("request raised without exceeding core priority");
	chk_zero_prio_off: assert property (@(posedge ref_clk) disable iff (srst)
		core_req.irq |-> core_req.level != '0) else $error("disabled priority forwarded");
	chk_single_vec_zero: assert property (@(posedge ref_clk) disable iff (srst)
		ce && !multi_vector_select |=> core_req.vector == '0) else $error("single-vector vector not zero");
	chk_single_vec_set: assert property (@(posedge ref_clk) disable iff (srst)
		ce && found && !multi_vector_select |=> core_req.shadow == ($past(ss0) ? SV_SHADOW_SET : PRIMARY_SET))
		else $error("single-vector register set wrong");
	chk_multi_vec_set: assert property (@(posedge ref_clk) disable iff (srst)
		ce && found && multi_vector_select && map_set > MAX_SHADOW_SET |=> core_req.shadow == PRIMARY_SET)
		else $error("unimplemented shadow set used");
	chk_timer_reload: assert property (@(posedge ref_clk) disable iff (srst)
		low_load_s |=> cnt_q == $past(reload_q)) else $error("timer not reloaded");
	chk_timer_step: assert property (@(posedge ref_clk) disable iff (srst)
		count_step_s |=> cnt_q == $past(cnt_q) - 32'h00000001) else $error("timer did not step");
	chk_timer_off: assert property (@(posedge ref_clk) disable iff (srst)
		ce && proximity_priority_threshold == '0 |=> cnt_q == '0) else $error("timer runs with zero threshold");
	chk_hold_low: assert property (@(posedge ref_clk) disable iff (srst)
		ce && proximity_priority_threshold != '0 && cnt_q != '0 |=> !core_req.irq || core_req.level > $past(proximity_priority_threshold))
		else $error("low request passed during window");
	chk_ext_flag: assert property (@(posedge ref_clk) disable iff (srst)
		ce && ext_edge != '0 |=> (flag_q[EXT_VEC_BASE +: NUM_EXT] & $past(ext_edge)) ==
		$past(ext_edge)) else $error("external edge lost");

endmodule

// ==== core_model.sv ====
module core_model
	import intc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic take,
	input wire logic done,
	input wire core_req_s core_req,
	output logic [PRIO_W-1:0] core_current_priority
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========
	// Handler entry raises the level; return drops it to zero
	always_ff @(posedge ref_clk) begin
		if (srst || done) begin
			core_current_priority <= '0;
		end else if (take && core_req.irq) begin
			core_current_priority <= core_req.level;
		end
	end
endmodule

// ==== vectored_priority_interrupt_ctrl_test.sv ====
module vectored_priority_interrupt_ctrl_test import intc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk, srst, ce, psel, penable, pwrite, pready, pslverr, take, done, err;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [NUM_VEC-1:0] src_event;
	logic [NUM_EXT-1:0] ext;
	logic [PRIO_W-1:0] core_prio;
	core_req_s core_req;
	int bad_count, samples_checked;
	vectored_priority_interrupt_ctrl uut (.ref_clk(ref_clk), .srst(srst), .ce(ce),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .src_event(src_event),
		.external_request_inputs(ext), .core_current_priority(core_prio), .core_req(core_req));
	core_model partner (.ref_clk(ref_clk), .srst(srst), .take(take), .done(done),
		.core_req(core_req), .core_current_priority(core_prio));
	// ==========
	// Tasks
	task automatic complete_run();
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic check(string name, logic [31:0] exp, logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic apb(logic [ADDR_W-1:0] a, logic w, logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the answer
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// An idle edge keeps the release apart from the next setup
		@(posedge ref_clk);
	endtask
	task automatic wr(logic [ADDR_W-1:0] a, logic [31:0] d);
		apb(a, 1'b1, d);
	endtask
	task automatic rdc(logic [ADDR_W-1:0] a, logic [31:0] exp, string name);
		apb(a, 1'b0, 32'h00000000);
		check(name, exp, r);
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic fire(logic [NUM_VEC-1:0] m);
		@(posedge ref_clk);
		src_event <= m;
		@(posedge ref_clk);
		src_event <= '0;
		cyc(3);
	endtask
	task automatic pulse_core(logic t);
		@(posedge ref_clk);
		take <= t;
		done <= !t;
		@(posedge ref_clk);
		take <= 1'b0;
		done <= 1'b0;
		cyc(3);
	endtask
	task automatic core(logic i, logic [2:0] l, logic [7:0] v, logic [3:0] s);
		check("core_req", {16'h0000, i, l, v, s}, {16'h0000, core_req});
	endtask
	// ==========
	// Clock, watchdog and tests
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	initial begin
		cyc(5000);
		bad_count++;
		complete_run();
	end
	initial begin
		{srst, ce, psel, penable, pwrite, take, done} = 7'b1100000;
		{paddr, pwdata, src_event, ext} = '0;
		cyc(8);
		srst <= 1'b0;
		rdc(REG_CTRL, 32'h00000000, "ctrl_reset");
		apb(12'h0C0, 1'b0, 32'h00000000);
		check("unmapped_err", 32'h1, {31'h0, err});
		wr(REG_CTRL, 32'h00001000);
		wr(REG_CTRL + 12'h8, 32'h00000300);
		wr(REG_CTRL + 12'h4, 32'h00000100);
		rdc(REG_CTRL, 32'h00001200, "ctrl_ops");
		wr(REG_CTRL, 32'h00001000);
		wr(12'h070, 32'h00131010);
		wr(12'h060, 32'h00180800);
		wr(REG_EN, 32'h000000F6);
		fire(16'h0080);
		core(0, 0, 0, 0);
		fire(16'h0030);
		core(1, 4, 4, 0);
		fire(16'h0040);
		core(1, 4, 6, 0);
		pulse_core(1'b1);
		core(0, 4, 6, 0);
		fire(16'h0002);
		core(0, 4, 6, 0);
		fire(16'h0004);
		core(1, 6, 2, 0);
		wr(REG_SMAP, 32'h01000000);
		cyc(3);
		core(1, 6, 2, 1);
		wr(REG_SMAP, 32'h05000000);
		cyc(3);
		core(1, 6, 2, 0);
		wr(REG_CTRL + 12'h4, 32'h00001000);
		wr(REG_CTRL + 12'h8, 32'h00010000);
		cyc(3);
		core(1, 6, 0, 1);
		wr(REG_CTRL + 12'h4, 32'h00010000);
		cyc(3);
		core(1, 6, 0, 0);
		pulse_core(1'b0);
		wr(REG_FLAG + 12'h4, 32'h0000FFFF);
		wr(12'h068, 32'h14000000);
		@(posedge ref_clk);
		ext[0] <= 1'b1;
		cyc(8);
		rdc(REG_FLAG, 32'h00000000, "flag_rise_ignored");
		ext[0] <= 1'b0;
		cyc(8);
		rdc(REG_FLAG, 32'h00000008, "flag_fall");
		wr(REG_CTRL + 12'h8, 32'h00000010);
		wr(REG_FLAG + 12'h4, 32'h0000FFFF);
		ext[4] <= 1'b1;
		cyc(8);
		rdc(REG_FLAG, 32'h00000080, "flag_rise");
		wr(REG_FLAG + 12'h4, 32'h0000FFFF);
		wr(REG_CTRL, 32'h00001300);
		wr(REG_TMR, 32'd40);
		fire(16'h0002);
		core(0, 0, 0, 0);
		apb(REG_TMR, 1'b0, 32'h00000000);
		check("tmr_running", 32'h1, {31'h0, (r != 32'h0 && r < 32'd40)});
		cyc(45);
		core(1, 2, 1, 0);
		rdc(REG_TMR, 32'd40, "tmr_reload");
		wr(REG_CTRL, 32'h00001000);
		wr(REG_FLAG + 12'h4, 32'h0000FFFF);
		fire(16'h0002);
		core(1, 2, 1, 0);
		rdc(REG_STAT, 32'h00000201, "stat_word");
		srst <= 1'b1;
		cyc(2);
		srst <= 1'b0;
		rdc(REG_CTRL, 32'h00000000, "ctrl_rerun");
		core(0, 0, 0, 0);
		complete_run();
	end
endmodule
